// File: rtl/ulpsc_ctrl.sv
// link power state controller for the active and low-power link states
// Operation
// - U0 runs a 1 ms receive-gap timer, restarted by each received link command.
// - U0 10 us transmit-idle timer held clear while sending, counts in idle.
// - on transmit-idle expiry send one LDN downstream or one LUP upstream.
// - U0 enters U1, U2 or U3 after its entry sequence completes.
// - downstream port failing U3 entry three times in a row goes Inactive.
// - U0 goes to Recovery on TS1, recovery-class error or directive.
// - fourth consecutive pending-header timeout goes Inactive; earlier ones go Recovery.
// - directed: downstream to Disabled or Inactive, upstream to Disabled.
// - missing port capability: downstream goes Inactive, upstream goes Disabled.
// - downstream U0 goes Recovery after 1 ms without a link command.
// - upstream U0 goes Recovery after 1 ms without link command or packet.
// - warm reset, directed on a downstream port or detected on an upstream port, moves U0-U3 to Rx.Detect.
// - self-powered upstream port in U0 goes Disabled when VBUS drops.
// - U1 starts a non-zero U2 inactivity timer; expiry moves to U2.
// - downstream U1 300 ms ping timer, restarted by pings; expiry to Rx.Detect.
// - upstream port in U1 sends periodic ping LFPS.
// - U1/U2 exit handshake success goes Recovery; 2 ms failure goes Inactive.
// - self-powered upstream port in U1-U3 goes Disabled without valid VBUS.
// - downstream U2/U3 checks far-end termination every 100 ms; high-Z to Rx.Detect.
// - downstream U1 treats short pings as pings, only long LFPS as exit.
// - U3 disables ping detection and enables wakeup detection.
// - U3 wake success goes Recovery; 10 ms failure stays, retries after 100 ms.
`timescale 1ns/100ps
module ulpsc_ctrl #(
  parameter logic [ulpsc_pkg::TMR_W-1:0] U0_RX_CYC    = ulpsc_pkg::TMR_W'(ulpsc_pkg::U0_RX_CYC),
  parameter logic [ulpsc_pkg::TMR_W-1:0] U1_PING_CYC  = ulpsc_pkg::TMR_W'(ulpsc_pkg::U1_PING_CYC),
  parameter logic [ulpsc_pkg::TMR_W-1:0] HS_U12_CYC   = ulpsc_pkg::TMR_W'(ulpsc_pkg::HS_U12_CYC),
  parameter logic [ulpsc_pkg::TMR_W-1:0] HS_U3_CYC    = ulpsc_pkg::TMR_W'(ulpsc_pkg::HS_U3_CYC),
  parameter logic [ulpsc_pkg::TMR_W-1:0] RETRY_CYC    = ulpsc_pkg::TMR_W'(ulpsc_pkg::U3_RETRY_CYC),
  parameter logic [ulpsc_pkg::TMR_W-1:0] RXDET_CYC    = ulpsc_pkg::TMR_W'(ulpsc_pkg::RXDET_CYC),
  parameter logic [ulpsc_pkg::TMR_W-1:0] PING_TX_CYC  = ulpsc_pkg::TMR_W'(ulpsc_pkg::PING_TX_CYC),
  parameter logic [ulpsc_pkg::TMR_W-1:0] PORT_CFG_CYC = ulpsc_pkg::TMR_W'(ulpsc_pkg::PORT_CFG_CYC)
) (
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  input  wire logic                         port_is_dsp,
  input  wire logic                         self_powered,
  input  wire logic [ulpsc_pkg::TMR_W-1:0]  u2_inact_cyc,
  input  wire logic                         u0_entry,
  input  wire logic                         cfg_start,
  input  wire logic                         port_cap_rx,
  input  wire logic                         rx_lcmd,
  input  wire logic                         rx_pkt,
  input  wire logic                         tx_busy,
  input  wire logic                         lgo_u1_done,
  input  wire logic                         lgo_u2_done,
  input  wire logic                         lgo_u3_done,
  input  wire logic                         lgo_u3_fail,
  input  wire logic                         ts1_det,
  input  wire logic                         link_err,
  input  wire logic                         pending_hp_timeout,
  input  wire logic                         hp_acked,
  input  wire logic                         dir_recovery,
  input  wire logic                         dir_disable,
  input  wire logic                         dir_inactive,
  input  wire logic                         dir_warm_reset,
  input  wire logic                         warm_reset_det,
  input  wire logic                         vbus_valid_pin,
  input  wire logic                         lfps_rx_pin,
  input  wire logic                         exit_req,
  input  wire logic                         lfps_hs_ok,
  input  wire logic                         rxdet_done,
  input  wire logic                         far_end_hi_z,
  output logic [2:0]                        link_state,
  output logic                              send_ldn,
  output logic                              send_lup,
  output logic                              ping_tx,
  output logic                              rxdet_start,
  output logic                              lfps_hs_start,
  output logic                              lfps_tx_en,
  output logic                              ping_det_en,
  output logic                              exit_det_en,
  output logic                              u3_wake_det_en
);

  localparam int unsigned W  = ulpsc_pkg::TMR_W;
  localparam int unsigned BW = ulpsc_pkg::BURST_W;

  ulpsc_pkg::ulpsc_state_type state_q, state_d, prev_q;

  logic          vbus_s1_q, vbus_s2_q;
  logic          lfps_s1_q, lfps_s2_q, lfps_d_q;
  logic [BW-1:0] burst_q;
  logic [1:0]    u3f_cnt_q, hp_cnt_q;
  logic          cfg_pend_q, hs_act_q, retry_q, hs_start_q;
  logic          ldn_q, lup_q, ping_tx_q, rxdet_q;
  logic          rx_to, tx_to, cfg_to, u2i_to, lp_done, hs_done;
  logic          in_u0, in_u1, in_u2, in_u3, in_lp;
  logic          warm, vbus_off, ping_rx, exit_lfps, hs_go, rx_clr, lp_en;
  logic [W-1:0]  lp_limit, hs_limit;

  assign in_u0 = (state_q == ulpsc_pkg::ST_U0);
  assign in_u1 = (state_q == ulpsc_pkg::ST_U1);
  assign in_u2 = (state_q == ulpsc_pkg::ST_U2);
  assign in_u3 = (state_q == ulpsc_pkg::ST_U3);
  assign in_lp = in_u1 || in_u2 || in_u3;

  // pins are asynchronous to core_clk
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vbus_s1_q <= 1'b0;
      vbus_s2_q <= 1'b0;
      lfps_s1_q <= 1'b0;
      lfps_s2_q <= 1'b0;
      lfps_d_q  <= 1'b0;
    end
    else
    begin
      vbus_s1_q <= vbus_valid_pin;
      vbus_s2_q <= vbus_s1_q;
      lfps_s1_q <= lfps_rx_pin;
      lfps_s2_q <= lfps_s1_q;
      lfps_d_q  <= lfps_s2_q;
    end
  end

  assign warm     = port_is_dsp ? dir_warm_reset : warm_reset_det;
  assign vbus_off = !port_is_dsp && self_powered && !vbus_s2_q;

  // burst length separates a short ping from an exit or wake burst
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      burst_q <= '0;
    else if (!lfps_s2_q)
      burst_q <= '0;
    else if (burst_q != {BW{1'b1}})
      burst_q <= burst_q + BW'(1);
  end

  assign ping_det_en    = port_is_dsp && in_u1;
  assign exit_det_en    = in_u1 || in_u2;
  assign u3_wake_det_en = in_u3;
  assign ping_rx   = ping_det_en && lfps_d_q && !lfps_s2_q
                     && (burst_q <= BW'(ulpsc_pkg::PING_MAX_CYC));
  assign exit_lfps = in_lp && lfps_s2_q
                     && (burst_q == BW'(ulpsc_pkg::PING_MAX_CYC + 1));

  // U0 timers
  assign rx_clr = !in_u0 || rx_lcmd || (!port_is_dsp && rx_pkt);

  ulpsc_timer #(.W(W)) u_rx_tmr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (rx_clr),
    .en       (in_u0),
    .limit    (U0_RX_CYC),
    .done     (rx_to)
  );

  ulpsc_timer #(.W(W)) u_tx_tmr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (!in_u0 || tx_busy),
    .en       (in_u0 && !tx_busy),
    .limit    (W'(ulpsc_pkg::U0_TX_CYC)),
    .done     (tx_to)
  );

  ulpsc_timer #(.W(W)) u_cfg_tmr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (!cfg_pend_q || cfg_start),
    .en       (in_u0 && cfg_pend_q),
    .limit    (PORT_CFG_CYC),
    .done     (cfg_to)
  );

  // low-power timers restart on every state change
  ulpsc_timer #(.W(W)) u_u2i_tmr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (!in_u1 || (prev_q != state_q)),
    .en       (in_u1 && !hs_act_q),
    .limit    (u2_inact_cyc),
    .done     (u2i_to)
  );

  assign lp_en    = in_u1 || ((in_u2 || in_u3) && port_is_dsp);
  assign lp_limit = in_u1 ? (port_is_dsp ? U1_PING_CYC : PING_TX_CYC) : RXDET_CYC;

  ulpsc_timer #(.W(W)) u_lp_tmr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (!lp_en || (prev_q != state_q) || ping_rx),
    .en       (lp_en),
    .limit    (lp_limit),
    .done     (lp_done)
  );

  assign hs_go    = in_lp && !hs_act_q && !retry_q && (exit_req || exit_lfps);
  assign hs_limit = in_u3 ? (retry_q ? RETRY_CYC : HS_U3_CYC) : HS_U12_CYC;

  ulpsc_timer #(.W(W)) u_hs_tmr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (!(hs_act_q || retry_q) || hs_go),
    .en       (hs_act_q || retry_q),
    .limit    (hs_limit),
    .done     (hs_done)
  );

  // handshake tracking; retry_q enforces the wake retry gap
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hs_act_q   <= 1'b0;
      retry_q    <= 1'b0;
      hs_start_q <= 1'b0;
    end
    else
    begin
      hs_start_q <= hs_go && !exit_lfps;
      if (!in_lp)
        hs_act_q <= 1'b0;
      else if (hs_go)
        hs_act_q <= 1'b1;
      else if (hs_act_q && (lfps_hs_ok || hs_done))
        hs_act_q <= 1'b0;
      if (!in_u3)
        retry_q <= 1'b0;
      else if (hs_act_q && hs_done && !lfps_hs_ok)
        retry_q <= 1'b1;
      else if (retry_q && hs_done)
        retry_q <= 1'b0;
    end
  end

  // consecutive-failure counters; a new event beats a same-cycle clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      u3f_cnt_q  <= 2'h0;
      hp_cnt_q   <= 2'h0;
      cfg_pend_q <= 1'b0;
    end
    else
    begin
      if (in_u0 && lgo_u3_fail && u3f_cnt_q != 2'h3)
        u3f_cnt_q <= u3f_cnt_q + 2'h1;
      else if (lgo_u3_done || state_q == ulpsc_pkg::ST_INACT)
        u3f_cnt_q <= 2'h0;
      if (in_u0 && pending_hp_timeout && hp_cnt_q != 2'h3)
        hp_cnt_q <= hp_cnt_q + 2'h1;
      else if (hp_acked || state_q == ulpsc_pkg::ST_INACT)
        hp_cnt_q <= 2'h0;
      if (cfg_start)
        cfg_pend_q <= 1'b1;
      else if (port_cap_rx)
        cfg_pend_q <= 1'b0;
    end
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ulpsc_pkg::ST_U0:
        if (warm)
          state_d = ulpsc_pkg::ST_RXDET;
        else if (vbus_off)
          state_d = ulpsc_pkg::ST_DISAB;
        else if (dir_disable)
          state_d = ulpsc_pkg::ST_DISAB;
        else if (port_is_dsp && dir_inactive)
          state_d = ulpsc_pkg::ST_INACT;
        else if (cfg_to)
          state_d = port_is_dsp ? ulpsc_pkg::ST_INACT : ulpsc_pkg::ST_DISAB;
        else if (pending_hp_timeout && hp_cnt_q == ulpsc_pkg::HP_TO_LIMIT)
          state_d = ulpsc_pkg::ST_INACT;
        else if (port_is_dsp && lgo_u3_fail && u3f_cnt_q == ulpsc_pkg::U3_FAIL_LIMIT)
          state_d = ulpsc_pkg::ST_INACT;
        else if (lgo_u1_done)
          state_d = ulpsc_pkg::ST_U1;
        else if (lgo_u2_done)
          state_d = ulpsc_pkg::ST_U2;
        else if (lgo_u3_done)
          state_d = ulpsc_pkg::ST_U3;
        else if (ts1_det || link_err || dir_recovery || pending_hp_timeout || rx_to)
          state_d = ulpsc_pkg::ST_RECOV;
      ulpsc_pkg::ST_U1, ulpsc_pkg::ST_U2, ulpsc_pkg::ST_U3:
        if (warm)
          state_d = ulpsc_pkg::ST_RXDET;
        else if (vbus_off || (port_is_dsp && dir_disable))
          state_d = ulpsc_pkg::ST_DISAB;
        else if (in_u1 && port_is_dsp && lp_done)
          state_d = ulpsc_pkg::ST_RXDET;
        else if (!in_u1 && port_is_dsp && rxdet_done && far_end_hi_z)
          state_d = ulpsc_pkg::ST_RXDET;
        else if (hs_act_q && lfps_hs_ok)
          state_d = ulpsc_pkg::ST_RECOV;
        else if (hs_act_q && hs_done && !in_u3)
          state_d = ulpsc_pkg::ST_INACT;
        else if (in_u1 && !hs_act_q && u2i_to)
          state_d = ulpsc_pkg::ST_U2;
      ulpsc_pkg::ST_RECOV, ulpsc_pkg::ST_RXDET, ulpsc_pkg::ST_INACT, ulpsc_pkg::ST_DISAB:
        if (u0_entry)
          state_d = ulpsc_pkg::ST_U0;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ulpsc_pkg::ST_RXDET;
      prev_q  <= ulpsc_pkg::ST_RXDET;
    end
    else
    begin
      state_q <= state_d;
      prev_q  <= state_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ldn_q     <= 1'b0;
      lup_q     <= 1'b0;
      ping_tx_q <= 1'b0;
      rxdet_q   <= 1'b0;
    end
    else
    begin
      ldn_q     <= tx_to && port_is_dsp;
      lup_q     <= tx_to && !port_is_dsp;
      ping_tx_q <= in_u1 && !port_is_dsp && lp_done;
      rxdet_q   <= (in_u2 || in_u3) && port_is_dsp && lp_done;
    end
  end

  assign link_state    = state_q;
  assign send_ldn      = ldn_q;
  assign send_lup      = lup_q;
  assign ping_tx       = ping_tx_q;
  assign rxdet_start   = rxdet_q;
  assign lfps_hs_start = hs_start_q;
  assign lfps_tx_en    = hs_act_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  ldn_single_a: assert property (send_ldn |-> port_is_dsp && !send_lup ##1 !send_ldn)
    else $error("ldn not a single pulse from a downstream port");
  tx_busy_hold_a: assert property (tx_busy |=> (!send_ldn && !send_lup)[*4])
    else $error("keep-alive sent while transmitting");
  warm_reset_a: assert property ((state_q inside {ulpsc_pkg::ST_U0, ulpsc_pkg::ST_U1,
      ulpsc_pkg::ST_U2, ulpsc_pkg::ST_U3}) && warm |=> state_q == ulpsc_pkg::ST_RXDET)
    else $error("warm reset did not move to rx detect");
  vbus_drop_a: assert property (in_u0 && vbus_off && !warm |=> state_q == ulpsc_pkg::ST_DISAB)
    else $error("vbus loss did not disable the port");
  u2_entry_a: assert property (in_u2 && prev_q == ulpsc_pkg::ST_U1 |-> $past(u2i_to))
    else $error("u1 to u2 without inactivity expiry");
  hs_fail_a: assert property (state_q == ulpsc_pkg::ST_INACT && (prev_q inside
      {ulpsc_pkg::ST_U1, ulpsc_pkg::ST_U2}) |-> $past(hs_act_q) && $past(hs_done))
    else $error("low power exit failure without handshake timeout");
  wake_retry_a: assert property (in_u3 && hs_act_q && hs_done && !lfps_hs_ok && !warm
      && !vbus_off && !(port_is_dsp && (dir_disable || rxdet_done)) |=> in_u3 && retry_q)
    else $error("failed wake did not hold u3 and wait to retry");
  u3_ping_off_a: assert property (in_u3 |-> !ping_det_en && u3_wake_det_en)
    else $error("ping detection active in u3");
  rxdet_period_a: assert property (rxdet_start |-> port_is_dsp && !in_u1 ##1 !rxdet_start[*8])
    else $error("termination check outside downstream u2 or u3");

endmodule : ulpsc_ctrl

// File: shared/ulpsc_pkg.sv
// constants and types for the link power state controller
package ulpsc_pkg;

  localparam int unsigned CLK_KHZ        = 25000;
  localparam int unsigned TMR_W          = 24;

  localparam int unsigned T_U0_RX_US     = 1000;
  localparam int unsigned T_U0_TX_US     = 10;
  localparam int unsigned T_U1_PING_MS   = 300;
  localparam int unsigned T_HS_U12_MS    = 2;
  localparam int unsigned T_HS_U3_MS     = 10;
  localparam int unsigned T_U3_RETRY_MS  = 100;
  localparam int unsigned T_RXDET_MS     = 100;
  localparam int unsigned T_PING_TX_MS   = 200;
  localparam int unsigned T_PORT_CFG_US  = 20;
  localparam int unsigned T_PING_MAX_NS  = 400;

  localparam int unsigned U0_RX_CYC      = (T_U0_RX_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned U0_TX_CYC      = (T_U0_TX_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned U1_PING_CYC    = T_U1_PING_MS * CLK_KHZ;
  localparam int unsigned HS_U12_CYC     = T_HS_U12_MS * CLK_KHZ;
  localparam int unsigned HS_U3_CYC      = T_HS_U3_MS * CLK_KHZ;
  localparam int unsigned U3_RETRY_CYC   = T_U3_RETRY_MS * CLK_KHZ;
  localparam int unsigned RXDET_CYC      = T_RXDET_MS * CLK_KHZ;
  localparam int unsigned PING_TX_CYC    = T_PING_TX_MS * CLK_KHZ;
  localparam int unsigned PORT_CFG_CYC   = (T_PORT_CFG_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned PING_MAX_CYC   = (T_PING_MAX_NS * CLK_KHZ) / 1000000;

  localparam int unsigned BURST_W        = 5;
  localparam logic [1:0]  U3_FAIL_LIMIT  = 2'h2;
  localparam logic [1:0]  HP_TO_LIMIT    = 2'h3;

  typedef enum logic [2:0] {
    ST_U0    = 3'h0,
    ST_U1    = 3'h1,
    ST_U2    = 3'h2,
    ST_U3    = 3'h3,
    ST_RECOV = 3'h4,
    ST_RXDET = 3'h5,
    ST_INACT = 3'h6,
    ST_DISAB = 3'h7
  } ulpsc_state_type;

endpackage : ulpsc_pkg

// File: rtl/ulpsc_timer.sv
// periodic terminal-count timer used by all link state timers
`timescale 1ns/100ps
module ulpsc_timer #(
  parameter int W = 24
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  logic [W-1:0] cnt_q;

  // a zero limit keeps the timer silent
  assign done = en && !clr && (limit != '0) && (cnt_q == limit - W'(1));

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= '0;
    else if (clr)
      cnt_q <= '0;
    else if (en)
      cnt_q <= done ? '0 : cnt_q + W'(1);
  end

endmodule : ulpsc_timer

// File: verification/ulpsc_partner.sv
// link partner model facing the power state controller
`timescale 1ns/100ps
module ulpsc_partner (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic lcmd_on,
  input  wire logic ping_on,
  input  wire logic long_on,
  input  wire logic hs_ack_on,
  input  wire logic hi_z,
  input  wire logic lfps_tx_en,
  input  wire logic rxdet_start,
  output logic      rx_lcmd,
  output logic      lfps_rx_pin,
  output logic      lfps_hs_ok,
  output logic      rxdet_done,
  output logic      far_end_hi_z
);
  logic [7:0] pcnt_q;
  logic [5:0] hcnt_q;
  logic [1:0] det_q;
  // one period counter: link commands every 30 cycles, ping bursts every 150
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pcnt_q <= 8'h00;
    else
      pcnt_q <= (pcnt_q == 8'h95) ? 8'h00 : pcnt_q + 8'h01;
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_lcmd     <= 1'h0;
      lfps_rx_pin <= 1'h0;
    end
    else
    begin
      rx_lcmd     <= lcmd_on && (pcnt_q % 8'h1E == 8'h00);
      // 5-cycle bursts sit well below the ping length limit
      lfps_rx_pin <= long_on || (ping_on && pcnt_q < 8'h05);
    end
  end
  // answers a handshake 20 cycles after it starts, only when told to
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hcnt_q     <= 6'h00;
      lfps_hs_ok <= 1'h0;
    end
    else
    begin
      hcnt_q     <= lfps_tx_en ? hcnt_q + 6'h01 : 6'h00;
      lfps_hs_ok <= hs_ack_on && hcnt_q == 6'h14;
    end
  end
  // result only valid with done; it toggles otherwise so nothing leans on it
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      det_q        <= 2'h0;
      rxdet_done   <= 1'h0;
      far_end_hi_z <= 1'h0;
    end
    else
    begin
      det_q        <= {det_q[0], rxdet_start};
      rxdet_done   <= det_q[1];
      far_end_hi_z <= det_q[1] ? hi_z : ~far_end_hi_z;
    end
  end
endmodule : ulpsc_partner

// File: verification/ulpsc_ctrl_tb.sv
// self-checking bench for the link power state controller
`timescale 1ns/100ps
module ulpsc_ctrl_tb;
  // shortened timer counts, in core clocks
  localparam logic [23:0] RXC   = 24'h190;
  localparam logic [23:0] PGC   = 24'h12C;
  localparam logic [23:0] H12   = 24'h3C;
  localparam logic [23:0] H3C   = 24'h50;
  localparam logic [23:0] RTY   = 24'h78;
  localparam logic [23:0] RDC   = 24'h64;
  localparam logic [23:0] PTX   = 24'h64;
  localparam logic [23:0] CFG   = 24'h32;
  localparam int          LIMIT = 32'h2710;
  logic        core_clk, resetn, port_is_dsp, self_powered, tx_busy, vbus, exit_req;
  logic [23:0] u2_inact_cyc;
  logic [16:0] ev;
  logic        lcmd_on, ping_on, long_on, hs_ack_on, hi_z;
  logic        rx_lcmd, lfps_rx_pin, lfps_hs_ok, rxdet_done, far_end_hi_z;
  logic [2:0]  link_state;
  logic        send_ldn, send_lup, ping_tx, rxdet_start, lfps_hs_start, lfps_tx_en;
  logic        ping_det_en, exit_det_en, u3_wake_det_en;
  int          miscompares, cmp_count, cyc, n_ldn, n_lup, n_png, n_rxs, n_hss;
  // pulse inputs ride on ev: 0 entry,1 cfg,2 cap,3 pkt,4-6 lgo,7 u3 fail,8 ts1,9 err,
  // 10 hp timeout,11 hp ack,12 recovery,13 disable,14 inactive,15 warm dir,16 warm det
  ulpsc_ctrl #(.U0_RX_CYC(RXC), .U1_PING_CYC(PGC), .HS_U12_CYC(H12), .HS_U3_CYC(H3C),
    .RETRY_CYC(RTY), .RXDET_CYC(RDC), .PING_TX_CYC(PTX), .PORT_CFG_CYC(CFG)) u_ulpsc_ctrl (
    .core_clk(core_clk), .resetn(resetn), .port_is_dsp(port_is_dsp),
    .self_powered(self_powered), .u2_inact_cyc(u2_inact_cyc), .u0_entry(ev[0]),
    .cfg_start(ev[1]), .port_cap_rx(ev[2]), .rx_lcmd(rx_lcmd), .rx_pkt(ev[3]),
    .tx_busy(tx_busy), .lgo_u1_done(ev[4]), .lgo_u2_done(ev[5]), .lgo_u3_done(ev[6]),
    .lgo_u3_fail(ev[7]), .ts1_det(ev[8]), .link_err(ev[9]), .pending_hp_timeout(ev[10]),
    .hp_acked(ev[11]), .dir_recovery(ev[12]), .dir_disable(ev[13]), .dir_inactive(ev[14]),
    .dir_warm_reset(ev[15]), .warm_reset_det(ev[16]), .vbus_valid_pin(vbus),
    .lfps_rx_pin(lfps_rx_pin), .exit_req(exit_req), .lfps_hs_ok(lfps_hs_ok),
    .rxdet_done(rxdet_done), .far_end_hi_z(far_end_hi_z), .link_state(link_state),
    .send_ldn(send_ldn), .send_lup(send_lup), .ping_tx(ping_tx), .rxdet_start(rxdet_start),
    .lfps_hs_start(lfps_hs_start), .lfps_tx_en(lfps_tx_en), .ping_det_en(ping_det_en),
    .exit_det_en(exit_det_en), .u3_wake_det_en(u3_wake_det_en));
  ulpsc_partner u_ulpsc_partner (.core_clk(core_clk), .resetn(resetn), .lcmd_on(lcmd_on),
    .ping_on(ping_on), .long_on(long_on), .hs_ack_on(hs_ack_on), .hi_z(hi_z),
    .lfps_tx_en(lfps_tx_en), .rxdet_start(rxdet_start), .rx_lcmd(rx_lcmd),
    .lfps_rx_pin(lfps_rx_pin), .lfps_hs_ok(lfps_hs_ok), .rxdet_done(rxdet_done),
    .far_end_hi_z(far_end_hi_z));
  always #20 core_clk = ~core_clk;
  // pulses are counted on the falling edge, where registered outputs have settled
  always @(negedge core_clk)
  begin
    cyc   = cyc + 1;
    n_ldn = n_ldn + send_ldn;
    n_lup = n_lup + send_lup;
    n_png = n_png + ping_tx;
    n_rxs = n_rxs + rxdet_start;
    n_hss = n_hss + lfps_hs_start;
    if (cyc == LIMIT)
    begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  // trailing idle cycle keeps two pulses from landing in one time step
  task automatic pulse(input logic [16:0] m);
    ev = m;
    tick(1);
    ev = 17'h0;
    tick(1);
  endtask : pulse
  task automatic wait_state(input logic [2:0] e, input int lim);
    int i;
    i = 0;
    while (link_state !== e && i < lim)
    begin
      tick(1);
      i++;
    end
    chk(link_state, e);
  endtask : wait_state
  task automatic go_u0();
    pulse(17'h18000);
    pulse(17'h5);
    wait_state(ulpsc_pkg::ST_U0, 3);
  endtask : go_u0
  task automatic t_keepalive();
    go_u0();
    tx_busy = 1'h1;
    n_ldn = 0;
    tick(300);
    chk(n_ldn, 0);
    tx_busy = 1'h0;
    n_ldn = 0;
    n_lup = 0;
    tick(ulpsc_pkg::U0_TX_CYC - 5);
    chk(n_ldn, 0);
    tick(10);
    chk(n_ldn, 1);
    chk(n_lup, 0);
    chk(link_state, ulpsc_pkg::ST_U0);
    lcmd_on = 1'h0;
    tick(RXC - 40);
    chk(link_state, ulpsc_pkg::ST_U0);
    wait_state(ulpsc_pkg::ST_RECOV, 50);
    lcmd_on = 1'h1;
  endtask : t_keepalive
  task automatic t_u0_exits();
    logic [16:0] mk [9];
    logic [2:0]  ex [9];
    mk = '{17'h10, 17'h20, 17'h40, 17'h100, 17'h200, 17'h1000, 17'h2000, 17'h4000, 17'h8000};
    ex = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h7, 3'h6, 3'h5};
    for (int i = 0; i < 9; i++)
    begin
      go_u0();
      pulse(mk[i]);
      wait_state(ex[i], 3);
    end
  endtask : t_u0_exits
  task automatic t_counts();
    go_u0();
    pulse(17'h80);
    pulse(17'h80);
    chk(link_state, ulpsc_pkg::ST_U0);
    pulse(17'h80);
    wait_state(ulpsc_pkg::ST_INACT, 3);
    go_u0();
    pulse(17'h400);
    wait_state(ulpsc_pkg::ST_RECOV, 3);
    go_u0();
    pulse(17'h800);
    for (int i = 0; i < 3; i++)
    begin
      pulse(17'h400);
      wait_state(ulpsc_pkg::ST_RECOV, 3);
      go_u0();
    end
    pulse(17'h400);
    wait_state(ulpsc_pkg::ST_INACT, 3);
    go_u0();
    pulse(17'h2);
    pulse(17'h4);
    tick(CFG + 10);
    chk(link_state, ulpsc_pkg::ST_U0);
    pulse(17'h2);
    tick(CFG - 10);
    chk(link_state, ulpsc_pkg::ST_U0);
    wait_state(ulpsc_pkg::ST_INACT, 20);
  endtask : t_counts
  task automatic t_u1();
    go_u0();
    pulse(17'h10);
    chk(ping_det_en, 1);
    chk(exit_det_en, 1);
    ping_on = 1'h1;
    tick(PGC + 200);
    chk(link_state, ulpsc_pkg::ST_U1);
    ping_on = 1'h0;
    wait_state(ulpsc_pkg::ST_RXDET, PGC + 160);
    go_u0();
    pulse(17'h10);
    hs_ack_on = 1'h1;
    exit_req = 1'h1;
    n_hss = 0;
    wait_state(ulpsc_pkg::ST_RECOV, 40);
    chk(n_hss, 1);
    exit_req = 1'h0;
    go_u0();
    pulse(17'h20);
    hs_ack_on = 1'h0;
    exit_req = 1'h1;
    tick(H12 - 10);
    chk(link_state, ulpsc_pkg::ST_U2);
    wait_state(ulpsc_pkg::ST_INACT, 30);
    exit_req = 1'h0;
  endtask : t_u1
  task automatic t_u2();
    u2_inact_cyc = 24'h1E;
    go_u0();
    pulse(17'h10);
    tick(20);
    chk(link_state, ulpsc_pkg::ST_U1);
    wait_state(ulpsc_pkg::ST_U2, 20);
    chk(exit_det_en, 1);
    ping_on = 1'h1;
    n_rxs = 0;
    tick(RDC * 3 + 50);
    chk(link_state, ulpsc_pkg::ST_U2);
    chk(n_rxs, 3);
    ping_on = 1'h0;
    hi_z = 1'h1;
    wait_state(ulpsc_pkg::ST_RXDET, RDC + 10);
    hi_z = 1'h0;
    u2_inact_cyc = 24'h0;
    go_u0();
    pulse(17'h20);
    hs_ack_on = 1'h1;
    long_on = 1'h1;
    wait_state(ulpsc_pkg::ST_RECOV, 60);
    long_on = 1'h0;
    hs_ack_on = 1'h0;
  endtask : t_u2
  task automatic t_u3();
    go_u0();
    pulse(17'h40);
    chk(u3_wake_det_en, 1);
    chk(ping_det_en, 0);
    chk(exit_det_en, 0);
    exit_req = 1'h1;
    n_hss = 0;
    tick(5);
    chk(n_hss, 1);
    chk(lfps_tx_en, 1);
    tick(H3C + 100);
    chk(link_state, ulpsc_pkg::ST_U3);
    chk(lfps_tx_en, 0);
    chk(n_hss, 1);
    hs_ack_on = 1'h1;
    tick(60);
    chk(n_hss, 2);
    chk(link_state, ulpsc_pkg::ST_RECOV);
    exit_req = 1'h0;
    hs_ack_on = 1'h0;
  endtask : t_u3
  task automatic t_usp();
    resetn = 1'h0;
    port_is_dsp = 1'h0;
    self_powered = 1'h1;
    tick(10);
    resetn = 1'h1;
    go_u0();
    lcmd_on = 1'h0;
    n_ldn = 0;
    n_lup = 0;
    repeat (6)
    begin
      tick(100);
      pulse(17'h8);
    end
    chk(link_state, ulpsc_pkg::ST_U0);
    chk(n_lup, 2);
    chk(n_ldn, 0);
    pulse(17'h10);
    n_png = 0;
    tick(PTX * 2 + 10);
    chk(n_png, 2);
    vbus = 1'h0;
    wait_state(ulpsc_pkg::ST_DISAB, 8);
    vbus = 1'h1;
    tick(4);
    go_u0();
    // an upstream port ignores the directed warm reset and follows the detected one
    pulse(17'h8000);
    chk(link_state, ulpsc_pkg::ST_U0);
    pulse(17'h10000);
    wait_state(ulpsc_pkg::ST_RXDET, 3);
    go_u0();
    pulse(17'h2000);
    wait_state(ulpsc_pkg::ST_DISAB, 3);
    go_u0();
    vbus = 1'h0;
    wait_state(ulpsc_pkg::ST_DISAB, 8);
  endtask : t_usp
  task automatic complete_run();
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial
  begin
    {core_clk, resetn, self_powered, tx_busy, exit_req, ping_on, long_on, hs_ack_on} = 8'h0;
    {port_is_dsp, vbus, lcmd_on, hi_z} = 4'hE;
    u2_inact_cyc = 24'h0;
    ev = 17'h0;
    {miscompares, cmp_count, cyc, n_ldn, n_lup, n_png, n_rxs, n_hss} = '0;
    tick(10);
    resetn = 1'h1;
    t_keepalive();
    t_u0_exits();
    t_counts();
    t_u1();
    t_u2();
    t_u3();
    t_usp();
    complete_run();
  end
endmodule : ulpsc_ctrl_tb
